// [rtl/sec_port.v]
// serial echo command port: receiver, echo, line buffer, answer sender
// assumes the command interpreter sits outside on the same clock
`timescale 1ns/100ps
`include "sec_defines.vh"
// How it works
// - both directions run at 9600 baud, 8 data bits, no parity, one stop bit.
// - the first 63 characters of a line up to its LF, CR and LF included, are sent back on TXD; nothing is echoed after the LF until LINE_DONE.
// - answer characters go out only when no echo is pending; echo always goes first.
// - lines are ASCII and end in CR then LF.
// - an appended operation-complete query is answered with 1 then CR LF.
// - a whole line of up to 63 characters sent back to back is accepted, echoed in full, then answered.
// - only RXD and TXD carry data; modem lines are looped back inside.
// - the same framing, echo and line ending apply for RS-232 and USB.
// - several query answers go out in one line separated by semicolons.
module sec_port
(
  input  wire       CLK,
  input  wire       RSTN,
  input  wire       RXD,
  output reg        TXD,
  input  wire       DTR,
  output reg        DSR,
  output reg        CTS,
  output reg        LINE_RDY,
  output reg  [5:0] LINE_LEN,
  input  wire [5:0] LINE_ADDR,
  output reg  [7:0] LINE_DATA,
  input  wire       LINE_DONE,
  input  wire       ANS_VALID,
  input  wire [7:0] ANS_DATA,
  input  wire       ANS_LAST,
  input  wire       ANS_SEP,
  output reg        ANS_READY
);
  //------------------------------------------------------------
  // input synchronisers
  //------------------------------------------------------------
  reg rx_s1_ff, rx_s2_ff, dtr_s1_ff, dtr_s2_ff;
  always @(posedge CLK)
  begin
    if (!RSTN)
    begin
      rx_s1_ff  <= 1'b1;
      rx_s2_ff  <= 1'b1;
      dtr_s1_ff <= 1'b0;
      dtr_s2_ff <= 1'b0;
    end
    else
    begin
      rx_s1_ff  <= RXD;
      rx_s2_ff  <= rx_s1_ff;
      dtr_s1_ff <= DTR;
      dtr_s2_ff <= dtr_s1_ff;
    end
  end

  // modem lines looped back, no flow control
  always @(posedge CLK)
  begin
    if (!RSTN)
    begin
      DSR <= 1'b0;
      CTS <= 1'b0;
    end
    else
    begin
      DSR <= dtr_s2_ff;
      CTS <= dtr_s2_ff;
    end
  end

  //------------------------------------------------------------
  // receiver
  //------------------------------------------------------------
  reg [11:0] rx_cnt_ff;
  reg [3:0]  rx_bit_ff;
  reg [7:0]  rx_shf_ff;
  reg        rx_act_ff;
  reg        rx_stb_ff;
  reg [7:0]  rx_byte_ff;
  always @(posedge CLK)
  begin
    if (!RSTN)
    begin
      rx_cnt_ff  <= 12'h000;
      rx_bit_ff  <= 4'h0;
      rx_shf_ff  <= 8'h00;
      rx_act_ff  <= 1'b0;
      rx_stb_ff  <= 1'b0;
      rx_byte_ff <= 8'h00;
    end
    else
    begin
      rx_stb_ff <= 1'b0;
      if (!rx_act_ff)
      begin
        if (!rx_s2_ff)
        begin
          rx_act_ff <= 1'b1;
          rx_cnt_ff <= 12'h000;
          rx_bit_ff <= 4'h0;
        end
      end
      else if ((rx_bit_ff == 4'h0 && rx_cnt_ff == `SEC_HALF_CYC - 1) ||
               (rx_bit_ff != 4'h0 && rx_cnt_ff == `SEC_BIT_CYC - 1))
      begin
        rx_cnt_ff <= 12'h000;
        rx_bit_ff <= rx_bit_ff + 4'h1;
        if (rx_bit_ff == 4'h0 && rx_s2_ff)
          rx_act_ff <= 1'b0;
        else if (rx_bit_ff == 4'h9)
        begin
          rx_act_ff <= 1'b0;
          if (rx_s2_ff)
          begin
            rx_stb_ff  <= 1'b1;
            rx_byte_ff <= rx_shf_ff;
          end
        end
        else if (rx_bit_ff != 4'h0)
          rx_shf_ff <= {rx_s2_ff, rx_shf_ff[7:1]};
      end
      else
        rx_cnt_ff <= rx_cnt_ff + 12'h001;
    end
  end

  //------------------------------------------------------------
  // line buffer and echo queue
  //------------------------------------------------------------
  reg [7:0] line_mem [0:`SEC_LINE_DEPTH-1];
  reg [5:0] wr_ff;
  reg [5:0] echo_ff;
  reg       prev_cr_ff;
  reg       lf_seen_ff;
  reg [5:0] lf_pos_ff;
  always @(posedge CLK)
  begin
    if (rx_stb_ff && !LINE_RDY)
      line_mem[wr_ff] <= rx_byte_ff;
    LINE_DATA <= line_mem[LINE_ADDR];
  end

  // echo drains the buffer behind the receiver
  wire echo_pend = (echo_ff != wr_ff);
  wire tx_busy;
  reg  tx_go_ff;
  reg  [7:0] tx_dat_ff;
  reg  src_ans_ff;

  always @(posedge CLK)
  begin
    if (!RSTN)
    begin
      wr_ff      <= 6'h00;
      prev_cr_ff <= 1'b0;
      lf_seen_ff <= 1'b0;
      lf_pos_ff  <= 6'h00;
      LINE_RDY   <= 1'b0;
      LINE_LEN   <= 6'h00;
    end
    else
    begin
      if (rx_stb_ff && !LINE_RDY && !lf_seen_ff)
      begin
        if (wr_ff != 6'h3F)
          wr_ff <= wr_ff + 6'h01;
        prev_cr_ff <= (rx_byte_ff == `SEC_CHAR_CR);
        if (prev_cr_ff && rx_byte_ff == `SEC_CHAR_LF)
        begin
          lf_seen_ff <= 1'b1;
          lf_pos_ff  <= wr_ff;
        end
      end
      if (lf_seen_ff && !echo_pend && !tx_busy && !tx_go_ff)
      begin
        LINE_RDY   <= 1'b1;
        LINE_LEN   <= lf_pos_ff + 6'h01;
        lf_seen_ff <= 1'b0;
      end
      if (LINE_RDY && LINE_DONE)
      begin
        LINE_RDY   <= 1'b0;
        wr_ff      <= 6'h00;
        prev_cr_ff <= 1'b0;
      end
    end
  end

  //------------------------------------------------------------
  // transmit arbiter: echo first, then answer
  //------------------------------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_TAIL = 2'b01;
  reg [1:0] st_ff;
  reg [1:0] tail_ff;
  always @(posedge CLK)
  begin
    if (!RSTN)
    begin
      echo_ff    <= 6'h00;
      tx_go_ff   <= 1'b0;
      tx_dat_ff  <= 8'h00;
      src_ans_ff <= 1'b0;
      ANS_READY  <= 1'b0;
      st_ff      <= ST_IDLE;
      tail_ff    <= 2'b00;
    end
    else
    begin
      tx_go_ff  <= 1'b0;
      ANS_READY <= 1'b0;
      if (LINE_RDY && LINE_DONE)
        echo_ff <= 6'h00;
      case (st_ff)
        ST_IDLE:
        begin
          if (!tx_busy && !tx_go_ff && !ANS_READY)
          begin
            if (echo_pend)
            begin
              tx_dat_ff <= line_mem[echo_ff];
              tx_go_ff  <= 1'b1;
              echo_ff   <= echo_ff + 6'h01;
            end
            else if (ANS_VALID && LINE_RDY)
            begin
              tx_dat_ff <= ANS_SEP ? `SEC_CHAR_SEMI : ANS_DATA;
              tx_go_ff  <= 1'b1;
              ANS_READY <= 1'b1;
              if (ANS_LAST)
              begin
                st_ff   <= ST_TAIL;
                tail_ff <= 2'b00;
              end
            end
          end
        end
        ST_TAIL:
        begin
          if (!tx_busy && !tx_go_ff)
          begin
            tx_go_ff <= 1'b1;
            if (tail_ff == 2'b00)
            begin
              tx_dat_ff <= `SEC_CHAR_CR;
              tail_ff   <= 2'b01;
            end
            else
            begin
              tx_dat_ff <= `SEC_CHAR_LF;
              st_ff     <= ST_IDLE;
            end
          end
        end
        default:
          st_ff <= ST_IDLE;
      endcase
    end
  end

  //------------------------------------------------------------
  // transmitter
  //------------------------------------------------------------
  wire tx_line;
  sec_tx u_tx
  (
    .clk     (CLK),
    .rstn    (RSTN),
    .start   (tx_go_ff),
    .data    (tx_dat_ff),
    .busy_ff (tx_busy),
    .line_ff (tx_line)
  );

  always @(posedge CLK)
  begin
    if (!RSTN)
      TXD <= 1'b1;
    else
      TXD <= tx_line;
  end
endmodule // sec_port

// [inc/sec_defines.vh]
// constants for the serial echo command port
// assumes a 25 MHz system clock and a 9600 baud link
`ifndef SEC_DEFINES_VH
`define SEC_DEFINES_VH
`define SEC_CLK_HZ        25000000
`define SEC_BAUD          9600
`define SEC_BIT_CYC       (`SEC_CLK_HZ / `SEC_BAUD)
`define SEC_HALF_CYC      (`SEC_BIT_CYC / 2)
`define SEC_DATA_BITS     8
`define SEC_CHAR_CR       8'h0D
`define SEC_CHAR_LF       8'h0A
`define SEC_CHAR_SEMI     8'h3B
`define SEC_LINE_DEPTH    64
`define SEC_LINE_AW       6
`define SEC_ANS_DEPTH     64
`endif

// [rtl/sec_tx.v]
// serial transmitter: 8 data bits, no parity, 1 stop bit
// assumes CLK at 25 MHz; start is a one-cycle pulse taken while idle
`timescale 1ns/100ps
`include "sec_defines.vh"
module sec_tx
(
  input  wire       clk,
  input  wire       rstn,
  input  wire       start,
  input  wire [7:0] data,
  output reg        busy_ff,
  output reg        line_ff
);
  reg [11:0] cnt_ff;
  reg [3:0]  bit_ff;
  reg [8:0]  shf_ff;

  always @(posedge clk)
  begin
    if (!rstn)
    begin
      busy_ff <= 1'b0;
      line_ff <= 1'b1;
      cnt_ff  <= 12'h000;
      bit_ff  <= 4'h0;
      shf_ff  <= 9'h1FF;
    end
    else if (!busy_ff)
    begin
      if (start)
      begin
        busy_ff <= 1'b1;
        line_ff <= 1'b0;
        shf_ff  <= {1'b1, data};
        cnt_ff  <= 12'h000;
        bit_ff  <= 4'h0;
      end
    end
    else if (cnt_ff == `SEC_BIT_CYC - 1)
    begin
      cnt_ff <= 12'h000;
      if (bit_ff == 4'h9)
        busy_ff <= 1'b0;
      else
      begin
        line_ff <= shf_ff[0];
        shf_ff  <= {1'b1, shf_ff[8:1]};
        bit_ff  <= bit_ff + 4'h1;
      end
    end
    else
      cnt_ff <= cnt_ff + 12'h001;
  end
endmodule // sec_tx

// [sim/sec_checker.sv]
// assertions on the ports of the serial echo command port
// bound to sec_port; one clock, synchronous active-low reset
`timescale 1ns/100ps
module sec_checker
(
  input wire       CLK,
  input wire       RSTN,
  input wire       TXD,
  input wire       DTR,
  input wire       DSR,
  input wire       CTS,
  input wire       LINE_RDY,
  input wire [5:0] LINE_LEN,
  input wire       LINE_DONE,
  input wire       ANS_VALID,
  input wire       ANS_READY
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // ----------------
  // answer path
  // ----------------
  a_ready_one_cycle: assert property (ANS_READY |=> !ANS_READY)
    else $error("answer ready held too long");
  a_ready_has_cause: assert property (ANS_READY |-> $past(ANS_VALID) && $past(LINE_RDY))
    else $error("answer taken without offer");
  a_answer_starts: assert property (ANS_READY |-> ##2 !TXD)
    else $error("no start bit after answer taken");
  // ----------------
  // line hand-off
  // ----------------
  a_done_clears: assert property (LINE_RDY && LINE_DONE |=> !LINE_RDY)
    else $error("line ready not cleared");
  a_line_len: assert property (LINE_RDY |-> LINE_LEN >= 6'h02)
    else $error("line shorter than its ending");
  a_rdy_after_echo: assert property ($rose(LINE_RDY) |-> TXD && $past(TXD))
    else $error("line ready during echo");
  // ----------------
  // modem loopback
  // ----------------
  a_loop_high: assert property (DTR [*6] |-> CTS && DSR)
    else $error("loopback not high");
  a_loop_low: assert property (!DTR [*6] |-> !CTS && !DSR)
    else $error("loopback not low");
  c_answer: cover property (ANS_READY);
  c_line: cover property ($rose(LINE_RDY));
  c_frame: cover property ($fell(TXD));
endmodule // sec_checker

bind sec_port sec_checker sec_checker_inst
(
  .CLK       (CLK),
  .RSTN      (RSTN),
  .TXD       (TXD),
  .DTR       (DTR),
  .DSR       (DSR),
  .CTS       (CTS),
  .LINE_RDY  (LINE_RDY),
  .LINE_LEN  (LINE_LEN),
  .LINE_DONE (LINE_DONE),
  .ANS_VALID (ANS_VALID),
  .ANS_READY (ANS_READY)
);

// [sim/sec_host.sv]
// control computer model: sends frames, collects frames sent back
// assumes CLK is the device clock; inputs change at its falling edge
`timescale 1ns/100ps
`include "sec_defines.vh"
module sec_host
(
  input wire CLK,
  input wire TXD,
  output reg RXD
);
  logic [7:0] rx_q[$];
  initial RXD = 1'b1;
  // one frame, start, lsb first, stop
  task send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(negedge CLK);
      RXD = f[i];
      repeat (`SEC_BIT_CYC - 1) @(negedge CLK);
    end
  endtask
  // receiver, mid-bit sampling
  always
  begin : rx
    logic [7:0] b;
    @(negedge TXD);
    repeat (`SEC_HALF_CYC) @(posedge CLK);
    for (int i = 0; i < 8; i++)
    begin
      repeat (`SEC_BIT_CYC) @(posedge CLK);
      b[i] = TXD;
    end
    repeat (`SEC_BIT_CYC) @(posedge CLK);
    if (TXD === 1'b1)
      rx_q.push_back(b);
  end
endmodule // sec_host

// [sim/sec_port_tb.sv]
// self-checking bench for the serial echo command port
// host model on the serial side, bench plays the interpreter
`timescale 1ns/100ps
`include "sec_defines.vh"
module sec_port_tb;
  logic       clk, rstn, dtr, line_done, ans_valid, ans_last, ans_sep;
  logic [5:0] line_addr;
  logic [7:0] ans_data;
  wire        rxd, txd, dsr, cts, line_rdy, ans_ready;
  wire  [5:0] line_len;
  wire  [7:0] line_data;
  integer     n_errors = 0;
  integer     checked = 0;
  integer     cyc = 0;
  sec_port sec_port_inst
  (
    .CLK(clk), .RSTN(rstn), .RXD(rxd), .TXD(txd), .DTR(dtr), .DSR(dsr),
    .CTS(cts), .LINE_RDY(line_rdy), .LINE_LEN(line_len), .LINE_ADDR(line_addr),
    .LINE_DATA(line_data), .LINE_DONE(line_done), .ANS_VALID(ans_valid),
    .ANS_DATA(ans_data), .ANS_LAST(ans_last), .ANS_SEP(ans_sep), .ANS_READY(ans_ready)
  );
  sec_host sec_host_inst (.CLK(clk), .TXD(txd), .RXD(rxd));
  // ----------------
  // helpers
  // ----------------
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked = checked + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wait_q(input integer n);
    for (int k = 0; k < 160000 && sec_host_inst.rx_q.size() < n; k++)
      @(negedge clk);
  endtask
  // offer one answer byte, hold it until taken
  task give_ans(input logic [7:0] d, input logic s, input logic l);
    ans_valid = 1'b1;
    ans_data = d;
    ans_sep = s;
    ans_last = l;
    @(negedge clk);
    for (int k = 0; k < 30000 && ans_ready !== 1'b1; k++)
      @(negedge clk);
    chk({7'h00, ans_ready}, 8'h01);
  endtask
  task print_verdict;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----------------
  // scenarios
  // ----------------
  task t_loop;
    dtr = 1'b1;
    repeat (8) @(negedge clk);
    chk({6'h00, dsr, cts}, 8'h03);
    dtr = 1'b0;
    repeat (8) @(negedge clk);
    chk({6'h00, dsr, cts}, 8'h00);
  endtask
  task t_line;
    sec_host_inst.send_byte(8'h31);
    sec_host_inst.send_byte(`SEC_CHAR_CR);
    wait_q(2);
    chk(sec_host_inst.rx_q[0], 8'h31);
    chk(sec_host_inst.rx_q[1], `SEC_CHAR_CR);
    // last character only after the echo of the one before
    sec_host_inst.send_byte(`SEC_CHAR_LF);
    wait_q(3);
    chk(sec_host_inst.rx_q[2], `SEC_CHAR_LF);
    // hand-off waits for the end of the LF echo stop bit
    for (int k = 0; k < 3000 && line_rdy !== 1'b1; k++)
      @(negedge clk);
    chk({7'h00, line_rdy}, 8'h01);
    chk({2'h0, line_len}, 8'h03);
    line_addr = 6'h02;
    repeat (2) @(negedge clk);
    chk(line_data, `SEC_CHAR_LF);
    line_addr = 6'h00;
    repeat (2) @(negedge clk);
    chk(line_data, 8'h31);
  endtask
  task t_answer;
    sec_host_inst.rx_q.delete();
    give_ans(8'h31, 1'b0, 1'b0);
    // separator byte: data must be replaced by ';'
    give_ans(8'h31, 1'b1, 1'b0);
    give_ans(8'h31, 1'b0, 1'b1);
    ans_valid = 1'b0;
    ans_sep = 1'b0;
    ans_last = 1'b0;
    wait_q(5);
    chk(sec_host_inst.rx_q[0], 8'h31);
    chk(sec_host_inst.rx_q[1], `SEC_CHAR_SEMI);
    chk(sec_host_inst.rx_q[2], 8'h31);
    chk(sec_host_inst.rx_q[3], `SEC_CHAR_CR);
    chk(sec_host_inst.rx_q[4], `SEC_CHAR_LF);
    line_done = 1'b1;
    @(negedge clk);
    line_done = 1'b0;
    @(negedge clk);
    chk({7'h00, line_rdy}, 8'h00);
  endtask
  // ----------------
  // clock, timeout, main
  // ----------------
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 300000)
    begin
      n_errors = n_errors + 1;
      print_verdict;
    end
  end
  initial
  begin
    rstn = 1'b0;
    dtr = 1'b0;
    line_done = 1'b0;
    ans_valid = 1'b0;
    ans_last = 1'b0;
    ans_sep = 1'b0;
    ans_data = 8'h00;
    line_addr = 6'h00;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    chk({7'h00, txd}, 8'h01);
    t_loop;
    t_line;
    t_answer;
    print_verdict;
  end
endmodule // sec_port_tb
